/* File: rtl/sound_readout_pkg.sv */
// Constants, register map and types for the two-wire register read-out port.
// Assumes one system clock; the host drives the link clock and data line.
package sound_readout_pkg;

  // ------------------------------------------------------------------
  // Widths and link constants
  // ------------------------------------------------------------------
  localparam int          BYTE_W         = 8;
  localparam int          SAMPLE_W       = 16;
  localparam int          GAIN_CODE_W    = 5;
  localparam int          GAIN_FACTOR_W  = 16;
  localparam int          GAIN_FRAC_BITS = 12;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic        ACK_LEVEL      = 1'b0;
  localparam logic [6:0]  DEVICE_ADDR    = 7'h5A;  // Arbitrary default bus address

  // ------------------------------------------------------------------
  // Subaddresses
  // ------------------------------------------------------------------
  localparam logic [7:0] SUB_DEVICE_STATUS     = 8'h00;
  localparam logic [7:0] SUB_DIGITAL_STATUS    = 8'h01;
  localparam logic [7:0] SUB_ERROR_COUNT       = 8'h02;
  localparam logic [7:0] SUB_ADD_DATA_LOW      = 8'h03;
  localparam logic [7:0] SUB_ADD_DATA_HIGH     = 8'h04;
  localparam logic [7:0] SUB_LEVEL_HIGH        = 8'h05;
  localparam logic [7:0] SUB_LEVEL_LOW         = 8'h06;
  localparam logic [7:0] SUB_SIGNAL_LEVEL      = 8'h07;
  localparam logic [7:0] SUB_SERIAL_OUT_GAIN   = 8'h17;
  localparam logic [7:0] SUB_TEST_SECOND       = 8'hFC;
  localparam logic [7:0] SUB_TEST_FIRST        = 8'hFD;
  localparam logic [7:0] SUB_PART_IDENTITY     = 8'hFE;
  localparam logic [7:0] SUB_FIRMWARE_IDENTITY = 8'hFF;

  // ------------------------------------------------------------------
  // Reset and fixed read values
  // ------------------------------------------------------------------
  localparam logic [7:0] GAIN_RESET        = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE    = 8'hFF;
  localparam logic [7:0] DEVICE_STATUS_USE = 8'hFE;
  localparam logic [7:0] ADD_DATA_HIGH_USE = 8'hDF;
  localparam logic [7:0] SIGNAL_LEVEL_USE  = 8'h1F;
  localparam logic [7:0] PART_ID_DEFAULT   = 8'hA5;  // Arbitrary value
  localparam logic [7:0] FW_ID_DEFAULT     = 8'h3C;  // Arbitrary value

  // ------------------------------------------------------------------
  // Gain factors, unsigned with 12 fraction bits; index is the 5-bit code
  // ------------------------------------------------------------------
  localparam logic [15:0] GAIN_TABLE [0:31] = '{
    16'h1000, 16'h11F4, 16'h1425, 16'h169A, 16'h195C, 16'h1C74, 16'h1FED, 16'h23D2,
    16'h2831, 16'h2D18, 16'h3299, 16'h38C5, 16'h3FB2, 16'h4778, 16'h5031, 16'h59FA,
    16'h02D8, 16'h0331, 16'h0395, 16'h0405, 16'h0482, 16'h050F, 16'h05AD, 16'h065F,
    16'h0726, 16'h0805, 16'h08FF, 16'h0A18, 16'h0B54, 16'h0CB6, 16'h0E43, 16'h1000
  };

  // ------------------------------------------------------------------
  // Link state machine
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    LINK_IDLE, LINK_ADDR, LINK_ADDR_ACK, LINK_SUB, LINK_SUB_ACK,
    LINK_WDATA, LINK_WDATA_ACK, LINK_RDATA, LINK_RACK, LINK_WAIT_STOP
  } link_state_t;

endpackage

/* File: rtl/line_events_if.sv */
// Carrier for conditioned link events between the pin sampler and the port logic.
// Assumes all signals are on the system clock.
`timescale 1ns/1ns
interface line_events_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic start_seen;
  logic stop_seen;

  modport sensor (output scl_rise, scl_fall, sda_level, start_seen, stop_seen);
  modport listener (input scl_rise, scl_fall, sda_level, start_seen, stop_seen);
endinterface

/* File: rtl/line_sampler.sv */
// Samples the link clock and data pins and finds edges, START and STOP.
// Assumes the link clock is far slower than the system clock.
`timescale 1ns/1ns
module line_sampler (
  input  wire logic         clock_in,
  input  wire logic         rst_b_in,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  line_events_if.sensor     events
);
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;

  // ------------------------------------------------------------------
  // Two-stage synchronisers, then one history stage
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // ------------------------------------------------------------------
  // Events
  // ------------------------------------------------------------------
  assign events.scl_rise   = scl_sync_reg & ~scl_prev_reg;
  assign events.scl_fall   = ~scl_sync_reg & scl_prev_reg;
  assign events.sda_level  = sda_sync_reg;
  assign events.start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign events.stop_seen  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
endmodule

/* File: rtl/output_gain.sv */
// Scales left and right samples by the programmed gain, saturating at full scale.
// Assumes samples arrive with a one-cycle valid strobe on the system clock.
`timescale 1ns/1ns
module output_gain #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_b_in,
  input  wire logic [4:0]                 gain_code_in,
  input  wire logic                       sample_valid_in,
  input  wire logic signed [SAMPLE_W-1:0] left_sample_in,
  input  wire logic signed [SAMPLE_W-1:0] right_sample_in,
  output logic                            sample_valid_out,
  output logic signed [SAMPLE_W-1:0]      left_sample_out,
  output logic signed [SAMPLE_W-1:0]      right_sample_out
);
  import sound_readout_pkg::*;

  localparam int PROD_W = SAMPLE_W + GAIN_FACTOR_W + 1;

  // ------------------------------------------------------------------
  // Scale one sample and clamp to the sample range
  // ------------------------------------------------------------------
  function automatic logic signed [SAMPLE_W-1:0] scale(
    input logic signed [SAMPLE_W-1:0] sample,
    input logic [GAIN_FACTOR_W-1:0]   factor
  );
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] shifted;
    prod    = sample * $signed({1'b0, factor});
    shifted = prod >>> GAIN_FRAC_BITS;
    if (shifted[PROD_W-1:SAMPLE_W-1] == {(PROD_W-SAMPLE_W+1){shifted[PROD_W-1]}}) begin
      scale = shifted[SAMPLE_W-1:0];
    end else if (shifted[PROD_W-1]) begin
      scale = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      scale = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
  endfunction

  logic [GAIN_FACTOR_W-1:0] factor;

  assign factor = GAIN_TABLE[gain_code_in];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sample_valid_out <= 1'b0;
      left_sample_out  <= '0;
      right_sample_out <= '0;
    end else begin
      sample_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        left_sample_out  <= scale(left_sample_in, factor);
        right_sample_out <= scale(right_sample_in, factor);
      end
    end
  end
endmodule

/* File: rtl/sound_readout_port.sv */
// Two-wire slave port: register read-out with auto-increment, output gain register.
// Assumes the host is bus master and the status inputs are on the system clock.
`timescale 1ns/1ns
module sound_readout_port #(
  parameter logic [6:0] BUS_ADDR      = sound_readout_pkg::DEVICE_ADDR,
  parameter logic [7:0] PART_IDENTITY = sound_readout_pkg::PART_ID_DEFAULT,
  parameter logic [7:0] FW_IDENTITY   = sound_readout_pkg::FW_ID_DEFAULT
) (
  input  wire logic                                          clock_in,
  input  wire logic                                          rst_b_in,
  input  wire logic                                          scl_in,
  input  wire logic                                          sda_in,
  output logic                                               sda_out,
  output logic                                               sda_oe_b_out,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          device_status_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          digital_sound_status_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          error_count_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          additional_data_low_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          additional_data_high_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          level_readout_high_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          level_readout_low_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          input_signal_level_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          test_second_in,
  input  wire logic [sound_readout_pkg::BYTE_W-1:0]          test_first_in,
  input  wire logic                                          sample_valid_in,
  input  wire logic signed [sound_readout_pkg::SAMPLE_W-1:0] left_sample_in,
  input  wire logic signed [sound_readout_pkg::SAMPLE_W-1:0] right_sample_in,
  output logic                                               sample_valid_out,
  output logic signed [sound_readout_pkg::SAMPLE_W-1:0]      left_sample_out,
  output logic signed [sound_readout_pkg::SAMPLE_W-1:0]      right_sample_out,
  output logic [sound_readout_pkg::BYTE_W-1:0]               serial_output_gain_out
);
  import sound_readout_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  link_state_t       state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [BYTE_W-1:0] rx_shift_reg;
  logic [BYTE_W-1:0] tx_shift_reg;
  logic [BYTE_W-1:0] pointer_reg;
  logic [BYTE_W-1:0] gain_reg;
  logic              read_dir_reg;
  logic              master_ack_reg;
  logic              sda_release_reg;

  logic              rx_state;
  logic              rx_done;
  logic              addr_hit;
  logic              load_tx;
  logic [BYTE_W-1:0] read_value;

  line_events_if ev ();

  line_sampler u_line_sampler (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .events   (ev.sensor)
  );

  // ------------------------------------------------------------------
  // Read map
  // ------------------------------------------------------------------
  function automatic logic [BYTE_W-1:0] read_byte(input logic [BYTE_W-1:0] sub);
    case (sub)
      SUB_DEVICE_STATUS:     read_byte = device_status_in & DEVICE_STATUS_USE;
      SUB_DIGITAL_STATUS:    read_byte = digital_sound_status_in;
      SUB_ERROR_COUNT:       read_byte = error_count_in;
      SUB_ADD_DATA_LOW:      read_byte = additional_data_low_in;
      SUB_ADD_DATA_HIGH:     read_byte = additional_data_high_in & ADD_DATA_HIGH_USE;
      SUB_LEVEL_HIGH:        read_byte = level_readout_high_in;
      SUB_LEVEL_LOW:         read_byte = level_readout_low_in;
      SUB_SIGNAL_LEVEL:      read_byte = input_signal_level_in & SIGNAL_LEVEL_USE;
      SUB_TEST_SECOND:       read_byte = test_second_in;
      SUB_TEST_FIRST:        read_byte = test_first_in;
      SUB_PART_IDENTITY:     read_byte = PART_IDENTITY;
      SUB_FIRMWARE_IDENTITY: read_byte = FW_IDENTITY;
      default:               read_byte = UNMAPPED_VALUE;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Decoded strobes
  // ------------------------------------------------------------------
  assign read_value = read_byte(pointer_reg);
  assign rx_state   = (state_reg == LINK_ADDR) || (state_reg == LINK_SUB)
                      || (state_reg == LINK_WDATA);
  assign rx_done    = rx_state && ev.scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
  assign addr_hit   = (rx_shift_reg[7:1] == BUS_ADDR);
  assign load_tx    = ev.scl_fall && !ev.start_seen && !ev.stop_seen
                      && (((state_reg == LINK_ADDR_ACK) && read_dir_reg)
                          || ((state_reg == LINK_RACK) && master_ack_reg));

  // ------------------------------------------------------------------
  // Link sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg       <= LINK_IDLE;
      bit_cnt_reg     <= '0;
      rx_shift_reg    <= '0;
      read_dir_reg    <= 1'b0;
      master_ack_reg  <= 1'b0;
      sda_release_reg <= 1'b1;
    end else if (ev.start_seen) begin
      state_reg       <= LINK_ADDR;
      bit_cnt_reg     <= '0;
      sda_release_reg <= 1'b1;
    end else if (ev.stop_seen) begin
      state_reg       <= LINK_IDLE;
      bit_cnt_reg     <= '0;
      sda_release_reg <= 1'b1;
    end else begin
      case (state_reg)
        LINK_ADDR, LINK_SUB, LINK_WDATA: begin
          if (ev.scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[BYTE_W-2:0], ev.sda_level};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end else if (rx_done) begin
            bit_cnt_reg <= '0;
            if (state_reg == LINK_ADDR) begin
              if (addr_hit) begin
                read_dir_reg    <= rx_shift_reg[0];
                sda_release_reg <= ACK_LEVEL;
                state_reg       <= LINK_ADDR_ACK;
              end else begin
                state_reg <= LINK_WAIT_STOP;
              end
            end else begin
              sda_release_reg <= ACK_LEVEL;
              state_reg       <= (state_reg == LINK_SUB) ? LINK_SUB_ACK : LINK_WDATA_ACK;
            end
          end
        end
        LINK_ADDR_ACK: begin
          if (ev.scl_fall) begin
            if (read_dir_reg) begin
              sda_release_reg <= read_value[BYTE_W-1];
              state_reg       <= LINK_RDATA;
            end else begin
              sda_release_reg <= 1'b1;
              state_reg       <= LINK_SUB;
            end
          end
        end
        LINK_SUB_ACK, LINK_WDATA_ACK: begin
          if (ev.scl_fall) begin
            sda_release_reg <= 1'b1;
            state_reg       <= LINK_WDATA;
          end
        end
        LINK_RDATA: begin
          if (ev.scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (ev.scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              bit_cnt_reg     <= '0;
              sda_release_reg <= 1'b1;
              state_reg       <= LINK_RACK;
            end else begin
              sda_release_reg <= tx_shift_reg[BYTE_W-2];
            end
          end
        end
        LINK_RACK: begin
          if (ev.scl_rise) begin
            master_ack_reg <= (ev.sda_level == ACK_LEVEL);
          end else if (ev.scl_fall) begin
            if (master_ack_reg) begin
              sda_release_reg <= read_value[BYTE_W-1];
              state_reg       <= LINK_RDATA;
            end else begin
              state_reg <= LINK_WAIT_STOP;
            end
          end
        end
        LINK_IDLE, LINK_WAIT_STOP: begin
          sda_release_reg <= 1'b1;
        end
        default: begin
          state_reg       <= LINK_IDLE;
          sda_release_reg <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_shift_reg <= UNMAPPED_VALUE;
    end else if (load_tx) begin
      tx_shift_reg <= read_value;
    end else if ((state_reg == LINK_RDATA) && ev.scl_fall && !ev.start_seen
                 && (bit_cnt_reg != BITS_PER_BYTE)) begin
      tx_shift_reg <= {tx_shift_reg[BYTE_W-2:0], 1'b1};
    end
  end

  // ------------------------------------------------------------------
  // Register pointer
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pointer_reg <= '0;
    end else if (rx_done && (state_reg == LINK_SUB)) begin
      pointer_reg <= rx_shift_reg;
    end else if ((rx_done && (state_reg == LINK_WDATA)) || load_tx) begin
      pointer_reg <= pointer_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // Output gain register
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gain_reg <= GAIN_RESET;
    end else if (rx_done && (state_reg == LINK_WDATA)
                 && (pointer_reg == SUB_SERIAL_OUT_GAIN)) begin
      gain_reg <= rx_shift_reg;
    end
  end

  output_gain #(
    .SAMPLE_W (SAMPLE_W)
  ) u_output_gain (
    .clock_in         (clock_in),
    .rst_b_in         (rst_b_in),
    .gain_code_in     (gain_reg[GAIN_CODE_W-1:0]),
    .sample_valid_in  (sample_valid_in),
    .left_sample_in   (left_sample_in),
    .right_sample_in  (right_sample_in),
    .sample_valid_out (sample_valid_out),
    .left_sample_out  (left_sample_out),
    .right_sample_out (right_sample_out)
  );

  // ------------------------------------------------------------------
  // Pins and register view
  // ------------------------------------------------------------------
  assign sda_out                = ACK_LEVEL;
  assign sda_oe_b_out           = sda_release_reg;
  assign serial_output_gain_out = gain_reg;
endmodule

/* File: tb/sound_readout_port_sva.sv */
// Checker for the read-out port pins and the gain path.
// Assumes it is bound into sound_readout_port and sees only its ports.
`timescale 1ns/1ns
module sound_readout_port_sva (
  input wire logic               clock_in,
  input wire logic               rst_b_in,
  input wire logic               scl_in,
  input wire logic               sda_out,
  input wire logic               sda_oe_b_out,
  input wire logic               sample_valid_in,
  input wire logic signed [15:0] left_sample_in,
  input wire logic signed [15:0] right_sample_in,
  input wire logic               sample_valid_out,
  input wire logic signed [15:0] left_sample_out,
  input wire logic signed [15:0] right_sample_out,
  input wire logic [7:0]         serial_output_gain_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  wire logic [4:0] code = serial_output_gain_out[4:0];
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  sequence s_take;
    sample_valid_in ##1 sample_valid_out;
  endsequence
  property p_valid;
    sample_valid_in |-> s_take;
  endproperty
  a_valid: assert property (p_valid) else $error("valid pulse missing");
  property p_unity;
    sample_valid_in && (code == 5'h00 || code == 5'h1F) |=> left_sample_out == $past(left_sample_in);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain altered sample");
  property p_same;
    sample_valid_in && left_sample_in == right_sample_in |=> left_sample_out == right_sample_out;
  endproperty
  a_same: assert property (p_same) else $error("channels scaled apart");
  property p_sat;
    sample_valid_in && !code[4] && left_sample_in == 16'sh7FFF |=> left_sample_out == 16'sh7FFF;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation at full scale");
  property p_cut;
    sample_valid_in && code[4] && code != 5'h1F && left_sample_in > 0
      |=> left_sample_out < $past(left_sample_in);
  endproperty
  a_cut: assert property (p_cut) else $error("negative gain did not attenuate");
  property p_hold;
    !sample_valid_out |-> $stable(left_sample_out) && $stable(right_sample_out);
  endproperty
  a_hold: assert property (p_hold) else $error("samples moved between pulses");
  property p_drive;
    $fell(sda_oe_b_out) |-> !scl_in && sda_out == 1'b0;
  endproperty
  a_drive: assert property (p_drive) else $error("data pull began with clock high");
  property p_quiet;
    scl_in && $past(scl_in) |-> $stable(sda_oe_b_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("data changed with clock high");
  property p_reset;
    $rose(rst_b_in) |-> serial_output_gain_out == 8'h00 && sda_oe_b_out && !sample_valid_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
bind sound_readout_port sound_readout_port_sva chk (.clock_in, .rst_b_in, .scl_in, .sda_out,
  .sda_oe_b_out, .sample_valid_in, .left_sample_in, .right_sample_in, .sample_valid_out,
  .left_sample_out, .right_sample_out, .serial_output_gain_out);

/* File: tb/host_master.sv */
// Behavioural two-wire bus master making the link clock and data line.
// Assumes a pull-up on the data wire; sda_wire_in is the resolved level.
`timescale 1ns/1ns
module host_master (
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_out
);
  // ------------------------------------------------------------------
  // Bus cycles; the link clock stands high between frames
  // ------------------------------------------------------------------
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic pulse(input logic b, output logic r);
    sda_out = b;
    #127 scl_out = 1'b1;
    #146 r = sda_wire_in;
    scl_out = 1'b0;
    #127;
  endtask
  task automatic start();
    sda_out = 1'b1;
    #127 scl_out = 1'b1;
    #146 sda_out = 1'b0;
    #127 scl_out = 1'b0;
    #127;
  endtask
  task automatic stop();
    sda_out = 1'b0;
    #127 scl_out = 1'b1;
    #146 sda_out = 1'b1;
    #146;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(b[i], r);
    pulse(1'b1, r);
    ack = !r;
  endtask
  // Every byte but the last is acknowledged
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(1'b1, b[i]);
    pulse(last, r);
  endtask
endmodule

/* File: tb/sound_readout_port_bench.sv */
// Self-checking bench: map reads, wrap, unmapped bytes, refusal, gain path.
// Assumes host_master and the bound checker are compiled alongside.
`timescale 1ns/1ns
module sound_readout_port_bench;
  import sound_readout_pkg::*;
  localparam logic [6:0] ADDR    = 7'h2C; // Arbitrary value
  localparam logic [7:0] PART_ID = 8'h6B; // Arbitrary value
  localparam logic [7:0] FW_ID   = 8'h92; // Arbitrary value
  logic              clock_in, rst_b_in, valid_in, valid_out, host_sda, scl, sda_out, oe_b, ack;
  logic [7:0]        src [0:9];
  logic [7:0]        gain, v, b;
  logic signed [15:0] left_in, right_in, left_out, right_out;
  wire logic         sda_wire = host_sda & (oe_b | sda_out);
  int                n_mismatch = 0, n_checks = 0, cyc = 0, seed = 94;
  host_master host (.sda_wire_in(sda_wire), .scl_out(scl), .sda_out(host_sda));
  sound_readout_port #(.BUS_ADDR(ADDR), .PART_IDENTITY(PART_ID), .FW_IDENTITY(FW_ID)) dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_b_out(oe_b), .device_status_in(src[0]),
    .digital_sound_status_in(src[1]), .error_count_in(src[2]), .additional_data_low_in(src[3]),
    .additional_data_high_in(src[4]), .level_readout_high_in(src[5]),
    .level_readout_low_in(src[6]), .input_signal_level_in(src[7]), .test_second_in(src[8]),
    .test_first_in(src[9]), .sample_valid_in(valid_in), .left_sample_in(left_in),
    .right_sample_in(right_in), .sample_valid_out(valid_out), .left_sample_out(left_out),
    .right_sample_out(right_out), .serial_output_gain_out(gain));
  // ------------------------------------------------------------------
  // Model and tasks
  // ------------------------------------------------------------------
  function automatic logic [7:0] expect_byte(logic [7:0] sub);
    case (sub)
      8'h00: return src[0] & 8'hFE;
      8'h04: return src[4] & 8'hDF;
      8'h07: return src[7] & 8'h1F;
      8'hFC: return src[8];
      8'hFD: return src[9];
      8'hFE: return PART_ID;
      8'hFF: return FW_ID;
      default: return (sub < 8) ? src[sub[2:0]] : 8'hFF;
    endcase
  endfunction
  // Negative codes run -15 dB at 0000 to -1 dB at 1110; 11111 lands on 0 dB
  function automatic int scale(int s, logic [4:0] c);
    int db;
    longint p;
    db = c[4] ? int'(c[3:0]) - 15 : int'(c[3:0]);
    p = longint'(s) * longint'($rtoi(4096.0 * 10.0 ** (db / 20.0) + 0.5));
    p = p >>> 12;
    return p > 32767 ? 32767 : (p < -32768 ? -32768 : int'(p));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic frame(input logic [7:0] sub);
    host.start();
    host.put({ADDR, 1'b0}, ack);
    check(16'(ack), 16'h1);
    host.put(sub, ack);
    check(16'(ack), 16'h1);
  endtask
  task automatic read_run(input logic [7:0] sub, input int n);
    logic [7:0] q [$];
    for (int i = 0; i < n; i++) q.push_back(expect_byte(8'(sub + i)));
    frame(sub);
    host.start();
    host.put({ADDR, 1'b1}, ack);
    check(16'(ack), 16'h1);
    for (int i = 0; i < n; i++) begin
      host.get(i == n - 1, b);
      check(16'(b), 16'(q.pop_front()));
    end
    host.stop();
    $display("read test from %h done", sub);
  endtask
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    valid_in = 1'b0;
    left_in = 16'h0;
    right_in = 16'h0;
    foreach (src[i]) src[i] = 8'($random(seed));
    repeat (20) @(posedge clock_in);
    #2;
    rst_b_in = 1'b1;
    check(16'(gain), 16'h0);
    repeat (4) @(posedge clock_in);
    read_run(8'h00, 8);
    foreach (src[i]) src[i] = 8'($random(seed));
    read_run(8'hFC, 6);
    read_run(8'h05, 4);
    read_run(SUB_SERIAL_OUT_GAIN, 1);
    host.start();
    host.put({~ADDR, 1'b0}, ack);
    check(16'(ack), 16'h0);
    host.stop();
    $display("refusal test done");
    // Byte at the neighbour subaddress is dropped, the next one lands in the gain register
    frame(8'h16);
    host.put(8'h9D, ack);
    check(16'(gain), 16'h0);
    host.put(8'h0B, ack);
    host.stop();
    check(16'(gain), 16'h0B);
    $display("write test done");
    for (int c = 0; c < 32; c++) begin
      v = {3'($random(seed)), 5'(c)};
      frame(SUB_SERIAL_OUT_GAIN);
      host.put(v, ack);
      host.stop();
      check(16'(gain), 16'(v));
      @(posedge clock_in);
      #2;
      valid_in = 1'b1;
      left_in = (c % 4 == 0) ? 16'sh7FFF : 16'($random(seed));
      right_in = (c % 4 == 1) ? left_in : 16'($random(seed));
      @(posedge clock_in);
      #2;
      valid_in = 1'b0;
      check(16'(valid_out), 16'h1);
      check(16'(left_out), 16'(scale(left_in, 5'(c))));
      check(16'(right_out), 16'(scale(right_in, 5'(c))));
    end
    $display("gain test done");
    end_sim();
  end
endmodule
